// ---- logic/aif_pkg.sv ----
// Constants shared by the analog I/O fault reporter files
`default_nettype none
package aif_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_IRQ_NUM    = 8'h04;
    localparam logic [7:0]  OFS_ERR_CODE   = 8'h08;
    localparam logic [7:0]  OFS_INT_STATUS = 8'h0c;
    localparam logic [7:0]  OFS_INT_MASK   = 8'h10;
    localparam logic [7:0]  OFS_LIVE       = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          NUM_CH         = 4;
    localparam int          POS_DET_EN     = 0;
    localparam int          POS_ALARM_SEL  = 4;
    localparam int          POS_CH_IRQ_EN  = 8;
    localparam int          POS_WARN_LED   = 12;
    localparam int          CTRL_WIDTH     = 13;
    localparam int          NUM_EVENTS     = 7;
    localparam int          IRQ_NUM_WIDTH  = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [12:0] CTRL_RESET     = 13'h10ff;
    localparam logic [7:0]  IRQ_NUM_RESET  = 8'h28;
    localparam logic [6:0]  MASK_RESET     = 7'h00;

    // ------------------------------------------------------------------
    // Error codes
    // ------------------------------------------------------------------
    localparam logic [15:0] CODE_NONE      = 16'h0000;
    localparam logic [15:0] CODE_HW_FAIL   = 16'ha600;
    localparam logic [15:0] CODE_SUPPLY    = 16'ha601;
    localparam logic [15:0] CODE_CAL_BAD   = 16'ha603;
    localparam logic [15:0] CODE_CH_ALARM  = 16'ha400;
    localparam logic [15:0] CODE_CH_WBLINK = 16'ha000;
    localparam logic [15:0] CODE_CH_WOFF   = 16'ha800;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_MHZ        = 200;
    localparam int          BLINK_HALF_MS  = 500;
    localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;

endpackage
`default_nettype wire

// ---- logic/aif_blink.sv ----
// Free-running square wave that paces the blinking error indicator
`timescale 1ns/10ps
`default_nettype none
module aif_blink #(
    parameter int unsigned HALF_CYC = aif_pkg::BLINK_HALF_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      blink
);
    if (HALF_CYC < 1) begin : g_chk
        $error("aif_blink: HALF_CYC must be at least 1");
    end

    logic [31:0] cnt;
    wire         wrap     = (cnt == 32'(HALF_CYC - 1));
    wire  [31:0] next_cnt = wrap ? 32'h0000_0000 : cnt + 32'h0000_0001;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt   <= 32'h0000_0000;
            blink <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            blink <= wrap ? ~blink : blink;
        end
    end
endmodule
`default_nettype wire

// ---- logic/aif_fault_reporter.sv ----
// Fault and status reporter of the four-input analog I/O module
// Notes on behaviour
// [RQ1] Hardware, supply and calibration faults each have a code; run LED off, error LED on.
// [RQ2] Alarm-channel over-range gives alarm base plus index; run LED off, error LED on.
// [RQ3] Blinking-kind warning gives its base plus index; run LED on, error LED blinking.
// [RQ4] Quiet-kind warning gives its base plus index; run LED on, error LED off.
// [RQ5] Each channel has its own interrupt number, reset to 40, raised on an out-of-range event.
// [RQ6] Each channel has a detect enable and an alarm/warning selector, reset on and alarm.
// [RQ7] A channel's over-range interrupt enable, reset off, gates its interrupt request.
// [RQ8] The warning LED setting, reset set, selects blinking over quiet warning codes.
`timescale 1ns/10ps
`default_nettype none
module aif_fault_reporter #(
    parameter int unsigned BLINK_HALF_CYC = aif_pkg::BLINK_HALF_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    input  wire logic        fault_hw,
    input  wire logic        fault_supply,
    input  wire logic        fault_cal,
    input  wire logic [3:0]  over_range,
    output logic             run_led,
    output logic             err_led,
    output logic      [15:0] err_code,
    output logic             irq,
    output logic             chan_int_req,
    output logic      [7:0]  chan_int_num
);
    if (BLINK_HALF_CYC < 1) begin : g_chk
        $error("aif_fault_reporter: BLINK_HALF_CYC must be at least 1");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [1:0] low_index(input logic [3:0] v);
        logic [1:0] idx;
        idx = 2'd0;
        for (int i = 3; i >= 0; i--) begin
            if (v[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [15:0] chan_code(input logic [15:0] base, input logic [1:0] idx);
        return base + {14'h0000, idx};
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers and event edges
    // ------------------------------------------------------------------
    // Fault and range flags arrive from pins and the converter front end,
    // so all of them pass two flip-flops before any decision looks at them.
    logic [6:0] sync_a;
    logic [6:0] sync_b;
    logic [6:0] sync_d;
    wire  [6:0] raw_in = {over_range, fault_cal, fault_supply, fault_hw};

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [12:0] ctrl;
    logic [31:0] irq_num;
    logic [6:0]  int_status;
    logic [6:0]  int_mask;
    logic [3:0]  pend;
    logic        blink;

    wire [3:0] det_en    = ctrl[aif_pkg::POS_DET_EN    +: aif_pkg::NUM_CH];
    wire [3:0] alarm_sel = ctrl[aif_pkg::POS_ALARM_SEL +: aif_pkg::NUM_CH];
    wire [3:0] ch_irq_en = ctrl[aif_pkg::POS_CH_IRQ_EN +: aif_pkg::NUM_CH];
    wire       warn_led  = ctrl[aif_pkg::POS_WARN_LED];

    wire       f_hw      = sync_b[0];
    wire       f_supply  = sync_b[1];
    wire       f_cal     = sync_b[2];
    wire [3:0] ch_over   = sync_b[6:3];
    wire       any_mod   = f_hw | f_supply | f_cal;

    wire [3:0] ch_det    = ch_over & det_en;                  // see [RQ6]
    wire [3:0] alarm_v   = ch_det & alarm_sel;                // see [RQ6]
    wire [3:0] warn_v    = ch_det & ~alarm_sel;
    wire [3:0] ch_rise   = ch_det & ~(sync_d[6:3] & det_en);
    wire [6:0] events    = {ch_rise, sync_b[2:0] & ~sync_d[2:0]};
    wire [3:0] new_int   = ch_rise & ch_irq_en;               // see [RQ7]

    // ------------------------------------------------------------------
    // Code and indicator selection
    // ------------------------------------------------------------------
    wire [15:0] warn_base = warn_led ? aif_pkg::CODE_CH_WBLINK        // see [RQ8]
                                     : aif_pkg::CODE_CH_WOFF;
    wire [15:0] warn_code = chan_code(warn_base, low_index(warn_v));  // see [RQ3] [RQ4]
    wire [15:0] alarm_code = chan_code(aif_pkg::CODE_CH_ALARM, low_index(alarm_v)); // see [RQ2]
    wire [15:0] next_err_code =
        f_hw       ? aif_pkg::CODE_HW_FAIL :                  // see [RQ1]
        f_supply   ? aif_pkg::CODE_SUPPLY  :
        f_cal      ? aif_pkg::CODE_CAL_BAD :
        |alarm_v   ? alarm_code            :
        |warn_v    ? warn_code             : aif_pkg::CODE_NONE;
    wire alarm_any   = any_mod | (|alarm_v);
    wire next_run    = ~alarm_any;                            // see [RQ1] [RQ2]
    wire next_err    = alarm_any | ((|warn_v) & warn_led & blink); // see [RQ3] [RQ4]

    // ------------------------------------------------------------------
    // Channel interrupt requests toward the controller
    // ------------------------------------------------------------------
    // One request per cycle; simultaneous events wait in pend so none is lost.
    wire [1:0] grant_idx = low_index(pend);
    wire [3:0] grant     = (|pend) ? (4'h1 << grant_idx) : 4'h0;
    wire [3:0] next_pend = (pend & ~grant) | new_int;         // see [RQ5] [RQ7]
    wire [7:0] next_num  = irq_num[grant_idx * aif_pkg::IRQ_NUM_WIDTH +: aif_pkg::IRQ_NUM_WIDTH];

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    wire wr_ctrl  = bus_wr && (bus_addr == aif_pkg::OFS_CTRL);
    wire wr_num   = bus_wr && (bus_addr == aif_pkg::OFS_IRQ_NUM);
    wire wr_stat  = bus_wr && (bus_addr == aif_pkg::OFS_INT_STATUS);
    wire wr_mask  = bus_wr && (bus_addr == aif_pkg::OFS_INT_MASK);
    wire [6:0] w1c = wr_stat ? bus_wdata[6:0] : 7'h00;
    // Hardware set beats the software clear in the same cycle.
    wire [6:0] next_status = (int_status & ~w1c) | events;

    wire [31:0] rd_mux =
        (bus_addr == aif_pkg::OFS_CTRL)       ? {19'h00000, ctrl} :
        (bus_addr == aif_pkg::OFS_IRQ_NUM)    ? irq_num :
        (bus_addr == aif_pkg::OFS_ERR_CODE)   ? {16'h0000, err_code} :
        (bus_addr == aif_pkg::OFS_INT_STATUS) ? {25'h0000000, int_status} :
        (bus_addr == aif_pkg::OFS_INT_MASK)   ? {25'h0000000, int_mask} :
        (bus_addr == aif_pkg::OFS_LIVE)       ? {25'h0000000, sync_b} : 32'h0000_0000;
    wire [31:0] next_rdata = bus_rd ? rd_mux : 32'h0000_0000;

    assign irq = |(int_status & int_mask);

    aif_blink #(
        .HALF_CYC (BLINK_HALF_CYC)
    ) u_blink (
        .clk      (clk),
        .rst_n    (rst_n),
        .blink    (blink)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
            sync_d <= 7'h00;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl       <= aif_pkg::CTRL_RESET;                 // see [RQ6] [RQ7] [RQ8]
            irq_num    <= {4{aif_pkg::IRQ_NUM_RESET}};         // see [RQ5]
            int_status <= 7'h00;
            int_mask   <= aif_pkg::MASK_RESET;
            bus_rdata  <= 32'h0000_0000;
        end else begin
            ctrl       <= wr_ctrl ? bus_wdata[12:0] : ctrl;
            irq_num    <= wr_num ? bus_wdata : irq_num;
            int_status <= next_status;
            int_mask   <= wr_mask ? bus_wdata[6:0] : int_mask;
            bus_rdata  <= next_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            err_code     <= aif_pkg::CODE_NONE;
            run_led      <= 1'b1;
            err_led      <= 1'b0;
            pend         <= 4'h0;
            chan_int_req <= 1'b0;
            chan_int_num <= 8'h00;
        end else begin
            err_code     <= next_err_code;
            run_led      <= next_run;
            err_led      <= next_err;
            pend         <= next_pend;
            chan_int_req <= |pend;                             // see [RQ5]
            chan_int_num <= (|pend) ? next_num : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_HW_CODE: assert property (@(posedge clk) disable iff (!rst_n) // see [RQ1]
        f_hw |=> (err_code == 16'ha600) && !run_led && err_led)
        else $error("hardware failure code or LEDs wrong");

    AST_CAL_CODE: assert property (@(posedge clk) disable iff (!rst_n) // see [RQ1]
        (f_cal && !f_hw && !f_supply) |=> (err_code == 16'ha603) && !run_led)
        else $error("calibration fault code wrong");

    AST_ALARM_CHAN: assert property (@(posedge clk) disable iff (!rst_n) // see [RQ2]
        (!any_mod && alarm_v[2] && alarm_v[1:0] == 2'b00)
        |=> (err_code == 16'ha402) && !run_led && err_led)
        else $error("channel alarm code or LEDs wrong");

    AST_WARN_BLINK: assert property (@(posedge clk) disable iff (!rst_n) // see [RQ3]
        (!any_mod && alarm_v == 4'h0 && warn_v[1] && !warn_v[0] && warn_led)
        |=> (err_code == 16'ha001) && run_led && (err_led == $past(blink)))
        else $error("blinking warning code or LEDs wrong");

    AST_WARN_OFF: assert property (@(posedge clk) disable iff (!rst_n) // see [RQ4] [RQ8]
        (!any_mod && alarm_v == 4'h0 && warn_v[3] && warn_v[2:0] == 3'h0 && !warn_led)
        |=> (err_code == 16'ha803) && run_led && !err_led)
        else $error("quiet warning code or LEDs wrong");

    AST_NUM_RESET: assert property (@(posedge clk) // see [RQ5]
        !rst_n |=> (irq_num == 32'h2828_2828) && (ctrl == 13'h10ff))
        else $error("interrupt numbers or control not at reset values");

    AST_INT_RAISED: assert property (@(posedge clk) disable iff (!rst_n) // see [RQ5]
        |new_int |-> ##[1:5] chan_int_req)
        else $error("channel interrupt not raised");

    AST_DET_OFF: assert property (@(posedge clk) disable iff (!rst_n) // see [RQ6]
        ((ch_over & det_en) == 4'h0 && !any_mod)
        |=> (err_code == 16'h0000) && run_led && !err_led)
        else $error("disabled detection still reports");

    AST_IRQ_GATE: assert property (@(posedge clk) disable iff (!rst_n) // see [RQ7]
        ((ch_rise & ~ch_irq_en) != 4'h0 && (ch_rise & ch_irq_en) == 4'h0 && pend == 4'h0)
        |=> ##1 !chan_int_req)
        else $error("channel interrupt raised while disabled");

    AST_RDATA_ONCE: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(bus_rd) |-> (bus_rdata == 32'h0000_0000))
        else $error("read data present without a read");

    COV_HW:     cover property (@(posedge clk) disable iff (!rst_n) err_code == 16'ha600);
    COV_ALARM:  cover property (@(posedge clk) disable iff (!rst_n) err_code[15:8] == 8'ha4);
    COV_WBLINK: cover property (@(posedge clk) disable iff (!rst_n)
        err_code[15:8] == 8'ha0 && err_led);
    COV_INT:    cover property (@(posedge clk) disable iff (!rst_n) chan_int_req ##1 chan_int_req);
endmodule
`default_nettype wire

// ---- verification/aif_cpu_model.sv ----
// Behavioural model of the controller CPU that takes channel interrupts
`timescale 1ns/10ps
`default_nettype none
module aif_cpu_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        chan_int_req,
    input  wire logic [7:0]  chan_int_num,
    output logic      [7:0]  int_count,
    output logic      [15:0] int_nums
);
    // Keeps the two latest numbers, newest in the low byte, so order is visible
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            int_count <= 8'h00;
            int_nums  <= 16'h0000;
        end else if (chan_int_req) begin
            int_count <= int_count + 8'h01;
            int_nums  <= {int_nums[7:0], chan_int_num};
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb_analog_io_fault_reporter.sv ----
// Self-checking testbench of the analog I/O fault reporter
`timescale 1ns/10ps
`default_nettype none
module tb_analog_io_fault_reporter;
    logic        clk;
    logic        rst_n;
    logic [7:0]  bus_addr;
    logic [31:0] bus_wdata;
    logic        bus_wr;
    logic        bus_rd;
    logic [31:0] bus_rdata;
    logic        fault_hw;
    logic        fault_supply;
    logic        fault_cal;
    logic [3:0]  over_range;
    logic        run_led;
    logic        err_led;
    logic [15:0] err_code;
    logic        irq;
    logic        chan_int_req;
    logic [7:0]  chan_int_num;
    logic [7:0]  int_count;
    logic [15:0] int_nums;
    int          mismatches;
    int          checks_done;

    // Short blink period keeps the blink visible within a few cycles
    aif_fault_reporter #(.BLINK_HALF_CYC(4)) aif_fault_reporter_i (
        .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .fault_hw(fault_hw), .fault_supply(fault_supply), .fault_cal(fault_cal),
        .over_range(over_range), .run_led(run_led), .err_led(err_led),
        .err_code(err_code), .irq(irq), .chan_int_req(chan_int_req),
        .chan_int_num(chan_int_num));
    aif_cpu_model aif_cpu_model_i (
        .clk(clk), .rst_n(rst_n), .chan_int_req(chan_int_req),
        .chan_int_num(chan_int_num), .int_count(int_count), .int_nums(int_nums));

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd   <= 1'b0;
        #1;
        chk(bus_rdata, exp);
    endtask
    // Two sync stages plus one register stage, then sample settled values
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic outchk(input logic [15:0] code, input logic run, input logic err);
        chk({14'h0, run_led, err_led, err_code}, {14'h0, run, err, code});
    endtask
    task automatic summarize();
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        #1;
        outchk(16'h0000, 1'b1, 1'b0);
        rchk(aif_pkg::OFS_CTRL, 32'h0000_10ff);
        rchk(aif_pkg::OFS_IRQ_NUM, 32'h2828_2828);
        rchk(aif_pkg::OFS_INT_MASK, 32'h0);
        wr(8'hfc, 32'hffff_ffff);
        rchk(8'hfc, 32'h0);
    endtask
    task automatic t_module_faults();
        logic [15:0] codes [3] = '{16'ha600, 16'ha601, 16'ha603};
        for (int i = 0; i < 3; i++) begin
            {fault_cal, fault_supply, fault_hw} <= 3'b001 << i;
            settle();
            outchk(codes[i], 1'b0, 1'b1);
        end
        over_range <= 4'hf;
        {fault_cal, fault_supply, fault_hw} <= 3'b111;
        settle();
        outchk(16'ha600, 1'b0, 1'b1);
        rchk(aif_pkg::OFS_INT_STATUS, 32'h0000_007f);
        over_range <= 4'h0;
        {fault_cal, fault_supply, fault_hw} <= 3'b000;
        settle();
        outchk(16'h0000, 1'b1, 1'b0);
    endtask
    task automatic t_alarm();
        for (int i = 0; i < 4; i++) begin
            over_range <= 4'h1 << i;
            settle();
            outchk(16'ha400 + 16'(i), 1'b0, 1'b1);
        end
        rchk(aif_pkg::OFS_ERR_CODE, 32'h0000_a403);
        rchk(aif_pkg::OFS_LIVE, 32'h0000_0040);
    endtask
    task automatic t_warn_blink();
        int highs;
        highs = 0;
        wr(aif_pkg::OFS_CTRL, 32'h0000_100f);
        for (int i = 0; i < 4; i++) begin
            over_range <= 4'h1 << i;
            settle();
            chk({run_led, err_code}, {1'b1, 16'ha000 + 16'(i)});
        end
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            #1;
            highs += int'(err_led === 1'b1);
        end
        chk(32'(highs > 0 && highs < 12), 32'h1);
    endtask
    task automatic t_warn_quiet();
        wr(aif_pkg::OFS_CTRL, 32'h0000_000f);
        for (int i = 0; i < 4; i++) begin
            over_range <= 4'h1 << i;
            settle();
            outchk(16'ha800 + 16'(i), 1'b1, 1'b0);
        end
        // Channel 3 with detection off must be ignored
        wr(aif_pkg::OFS_CTRL, 32'h0000_0007);
        settle();
        outchk(16'h0000, 1'b1, 1'b0);
        over_range <= 4'h0;
        settle();
    endtask
    task automatic t_irq();
        int n;
        chk(32'(int_count), 32'h0);
        wr(aif_pkg::OFS_CTRL, 32'h0000_16ff);
        wr(aif_pkg::OFS_IRQ_NUM, 32'h2d2c_2b2a);
        wr(aif_pkg::OFS_INT_STATUS, 32'h7f);
        over_range <= 4'b0110;
        for (n = 0; n < 20 && int_count !== 8'h02; n++) begin
            @(posedge clk);
        end
        if (n == 20) begin
            mismatches++;
            summarize();
        end
        #1;
        chk({int_count, 8'h0, int_nums}, 32'h0200_2b2c);
        rchk(aif_pkg::OFS_INT_STATUS, 32'h30);
        chk(32'(irq), 32'h0);
        wr(aif_pkg::OFS_INT_MASK, 32'h10);
        #1;
        chk(32'(irq), 32'h1);
        wr(aif_pkg::OFS_INT_STATUS, 32'h10);
        #1;
        chk(32'(irq), 32'h0);
        over_range <= 4'b1110;
        repeat (8) @(posedge clk);
        #1;
        chk(32'(int_count), 32'h2);
        rchk(aif_pkg::OFS_INT_STATUS, 32'h60);
        over_range <= 4'h0;
    endtask

    initial begin
        clk          = 1'b0;
        rst_n        = 1'b0;
        bus_addr     = 8'h00;
        bus_wdata    = 32'h0;
        bus_wr       = 1'b0;
        bus_rd       = 1'b0;
        fault_hw     = 1'b0;
        fault_supply = 1'b0;
        fault_cal    = 1'b0;
        over_range   = 4'h0;
        mismatches   = 0;
        checks_done  = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_module_faults();
        t_alarm();
        t_warn_blink();
        t_warn_quiet();
        t_irq();
        summarize();
    end

    // Cuts a hang short well inside the cycle budget
    initial begin
        #100us;
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
